/* rtl/quad_flash_core.sv */
// Purpose: quad read, wrapped burst and self-timed clear commands
// Assumes: link pins are asynchronous and sampled by CORE_CLK
// Notes: link clock must stay well below a quarter of CORE_CLK
module quad_flash_core #(
  parameter int ADDR_W = 19
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic CLK_EN,
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic [3:0] IO_IN,
  output logic [3:0] IO_OUT,
  output logic [3:0] IO_OE,
  input wire logic QUAD_LANE_ENABLE_BIT,
  input wire logic [3:0] PROTECT_LEVEL,
  output logic WRITE_IN_PROGRESS_FLAG,
  output logic WRITE_ENABLE_LATCH,
  output logic OPCODE_FREE_READ_MODE,
  output logic BURST_WRAP_ENABLE
);
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_CMD = 8'h02,
    ST_ADDR = 8'h04,
    ST_MODE = 8'h08,
    ST_DUMMY = 8'h10,
    ST_DATA = 8'h20,
    ST_ARG = 8'h40,
    ST_DROP = 8'h80
  } state_e;

  localparam int NBLK = 1 << (ADDR_W - flash_pkg::LARGE_SHIFT);
  localparam logic [ADDR_W-1:0] M_SEC =
    ADDR_W'((32'h1 << flash_pkg::SECTOR_SHIFT) - 32'h1);
  localparam logic [ADDR_W-1:0] M_HALF =
    ADDR_W'((32'h1 << flash_pkg::HALF_SHIFT) - 32'h1);
  localparam logic [ADDR_W-1:0] M_LARGE =
    ADDR_W'((32'h1 << flash_pkg::LARGE_SHIFT) - 32'h1);
  localparam logic [ADDR_W-1:0] M_CHIP = {ADDR_W{1'b1}};

  // top blocks are protected, more of them as the level rises
  function automatic logic prot_f(input logic [ADDR_W-1:0] a,
                                  input logic [3:0] bp);
    logic [7:0] from_top;
    // a shift, not a part-select, so a one-block array still elaborates
    from_top = 8'(NBLK - 1 - int'(a >> flash_pkg::LARGE_SHIFT));
    if (bp == 4'h0) return 1'b0;
    if (bp >= 4'h4) return 1'b1;
    return from_top < (8'h01 << (bp - 4'h1));
  endfunction

  function automatic logic [ADDR_W-1:0] next_f(input logic [ADDR_W-1:0] a,
                                               input logic w,
                                               input logic [ADDR_W-1:0] m);
    logic [ADDR_W-1:0] inc;
    inc = a + 1'b1;
    return w ? ((a & ~m) | (inc & m)) : inc;
  endfunction

  logic [7:0] mem [0:(1<<ADDR_W)-1];

  logic [2:0] cs_s;
  logic [2:0] clk_s;
  logic [3:0] io_m;
  logic [3:0] io_s;
  state_e state_q, state_d;
  logic [7:0] op_q, op_d;
  logic [4:0] cnt_q, cnt_d;
  logic [23:0] sr_q, sr_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic nib_q, nib_d;
  logic ofr_q, ofr_d;
  logic wrap_on_q, wrap_on_d;
  logic [1:0] wrap_sel_q, wrap_sel_d;
  logic latch_q, latch_d;
  logic busy_q, busy_d;
  logic [ADDR_W-1:0] ptr_q, ptr_d;
  logic [ADDR_W-1:0] mask_q, mask_d;
  logic [3:0] out_q, out_d;
  logic [3:0] oe_q, oe_d;
  logic start;

  // sampling taps of the synchronised link pins
  wire rise = CLK_EN & clk_s[1] & ~clk_s[2];
  wire fall = CLK_EN & ~clk_s[1] & clk_s[2];
  wire cs_rise = CLK_EN & cs_s[1] & ~cs_s[2];
  wire cs_fall = CLK_EN & ~cs_s[1] & cs_s[2];
  wire op_qio = (op_q == flash_pkg::OP_QUAD_IO);
  wire quad_in = (state_q == ST_ADDR && op_qio) || state_q == ST_MODE;
  wire [23:0] sr_sh = quad_in ? {sr_q[19:0], io_s} :
                                {sr_q[22:0], io_s[0]};
  wire [7:0] cmd = sr_sh[7:0];
  wire cmd_quad = cmd == flash_pkg::OP_QUAD_OUT ||
                  cmd == flash_pkg::OP_QUAD_IO;
  wire cmd_area = cmd == flash_pkg::OP_SECTOR ||
                  cmd == flash_pkg::OP_HALF || cmd == flash_pkg::OP_LARGE;
  wire cmd_bare = cmd == flash_pkg::OP_WR_ENABLE ||
                  cmd == flash_pkg::OP_CHIP || cmd == flash_pkg::OP_CHIP_ALT;
  // reads need quad lanes on and no write cycle running [RULE1] [RULE5]
  wire cmd_go = (cmd_quad && QUAD_LANE_ENABLE_BIT && !busy_q) ||
                cmd == flash_pkg::OP_WRAP || (cmd_area && !busy_q);
  // dual io read and unknown codes fall to the drop state [RULE11]
  wire state_e cmd_next = cmd_go ? ST_ADDR : cmd_bare ? ST_ARG : ST_DROP;
  // 24 serial address bits or 6 quad clocks [RULE4] [RULE6]
  wire [4:0] addr_last = op_qio ? flash_pkg::QIO_ADDR_LAST :
                         (op_q == flash_pkg::OP_WRAP) ? flash_pkg::WRAP_LAST :
                         flash_pkg::SER_ADDR_LAST;
  wire [4:0] dummy_last = op_qio ? flash_pkg::QIO_DUMMY_LAST :
                          flash_pkg::QOUT_DUMMY_LAST;
  // every nibble bit inverse of its partner keeps the mode [RULE7] [RULE10]
  wire mode_toggle = (sr_sh[7:4] ^ sr_sh[3:0]) == 4'hf;
  wire [7:0] wcode = sr_sh[7:0];
  wire [6:0] win_bytes = 7'(flash_pkg::WRAP_MIN_BYTES << wrap_sel_q);
  wire [ADDR_W-1:0] win_m = ADDR_W'(win_bytes - 7'h01);
  wire wrap_use = wrap_on_q & op_qio;
  wire [7:0] mem_rd = mem[addr_q];
  wire [ADDR_W-1:0] area_a = sr_q[ADDR_W-1:0];
  wire area_prot = prot_f(area_a, PROTECT_LEVEL);
  // region size picked by the clear opcode [RULE16] [RULE21]
  wire [ADDR_W-1:0] area_m = (op_q == flash_pkg::OP_SECTOR) ? M_SEC :
                             (op_q == flash_pkg::OP_HALF) ? M_HALF :
                             (op_q == flash_pkg::OP_LARGE) ? M_LARGE : M_CHIP;
  wire is_chip = op_q == flash_pkg::OP_CHIP ||
                 op_q == flash_pkg::OP_CHIP_ALT;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      cs_s <= 3'h7;
      clk_s <= 3'h0;
      io_m <= 4'h0;
      io_s <= 4'h0;
    end else if (CLK_EN) begin
      cs_s <= {cs_s[1:0], CS_N};
      clk_s <= {clk_s[1:0], SCLK};
      io_m <= IO_IN;
      io_s <= io_m;
    end
  end

  always_comb begin
    state_d = state_q;
    op_d = op_q;
    cnt_d = cnt_q;
    sr_d = sr_q;
    addr_d = addr_q;
    nib_d = nib_q;
    ofr_d = ofr_q;
    wrap_on_d = wrap_on_q;
    wrap_sel_d = wrap_sel_q;
    latch_d = latch_q;
    busy_d = busy_q;
    ptr_d = ptr_q;
    mask_d = mask_q;
    out_d = out_q;
    oe_d = oe_q;
    start = 1'b0;
    // self-timed clear walks its region one byte per enabled cycle
    if (busy_q && CLK_EN) begin
      if ((ptr_q & mask_q) == mask_q) begin
        busy_d = 1'b0; // [RULE19]
        latch_d = 1'b0; // [RULE19]
      end else begin
        ptr_d = ptr_q + 1'b1;
      end
    end
    if (cs_rise) begin
      state_d = ST_IDLE;
      oe_d = 4'h0;
      // only a command that ended exactly on its last bit gets here [RULE18]
      if (state_q == ST_ARG && !busy_q) begin
        case (op_q)
          flash_pkg::OP_WR_ENABLE: begin
            latch_d = 1'b1;
          end
          flash_pkg::OP_SECTOR, flash_pkg::OP_HALF,
          flash_pkg::OP_LARGE: begin
            if (latch_q && !area_prot) begin
              start = 1'b1; // [RULE16] [RULE21]
            end else if (latch_q && op_q == flash_pkg::OP_HALF) begin
              latch_d = 1'b0; // [RULE20]
            end
          end
          flash_pkg::OP_CHIP, flash_pkg::OP_CHIP_ALT: begin
            start = latch_q && PROTECT_LEVEL == 4'h0; // [RULE22]
          end
          default: begin
          end
        endcase
      end
    end else if (cs_fall) begin
      cnt_d = 5'h00;
      nib_d = 1'b0;
      if (ofr_q) begin
        // address comes first, no opcode clocks [RULE8]
        state_d = busy_q ? ST_DROP : ST_ADDR; // [RULE5]
        op_d = flash_pkg::OP_QUAD_IO;
      end else begin
        state_d = ST_CMD;
      end
    end else if (rise) begin
      cnt_d = cnt_q + 5'h01;
      sr_d = sr_sh; // [RULE2]
      case (state_q)
        ST_CMD: begin
          if (cnt_q == flash_pkg::CMD_LAST) begin
            op_d = cmd;
            cnt_d = 5'h00;
            state_d = cmd_next;
          end
        end
        ST_ADDR: begin
          if (cnt_q == addr_last) begin
            cnt_d = 5'h00;
            addr_d = sr_sh[ADDR_W-1:0];
            state_d = ST_ARG;
            if (op_qio) begin
              state_d = ST_MODE; // [RULE6]
            end else if (op_q == flash_pkg::OP_QUAD_OUT) begin
              state_d = ST_DUMMY; // [RULE4]
            end else if (op_q == flash_pkg::OP_WRAP) begin
              // wrap code byte taken here [RULE13]
              if (wcode[flash_pkg::WRAP_OFF_BIT]) begin
                wrap_on_d = 1'b0; // [RULE14]
              end else if ({wcode[7:5], wcode[3:2]} == 5'h00) begin
                wrap_on_d = 1'b1; // [RULE14]
                wrap_sel_d = wcode[1:0];
              end
            end
          end
        end
        ST_MODE: begin
          if (cnt_q == flash_pkg::MODE_LAST) begin
            cnt_d = 5'h00;
            ofr_d = mode_toggle; // [RULE7] [RULE9]
            state_d = ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          if (cnt_q == dummy_last) begin
            state_d = ST_DATA;
          end
        end
        ST_ARG: begin
          state_d = ST_DROP; // [RULE18]
        end
        default: begin
        end
      endcase
    end else if (fall && state_q == ST_DATA) begin
      // high nibble first, four lanes per clock [RULE2]
      oe_d = 4'hf;
      out_d = nib_q ? mem_rd[3:0] : mem_rd[7:4];
      nib_d = ~nib_q;
      if (nib_q) begin
        addr_d = next_f(addr_q, wrap_use, win_m); // [RULE3] [RULE15]
      end
    end
    if (start) begin
      busy_d = 1'b1; // [RULE19]
      mask_d = area_m;
      ptr_d = area_a & ~area_m;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      state_q <= ST_IDLE;
      op_q <= 8'h00;
      cnt_q <= 5'h00;
      sr_q <= 24'h000000;
      addr_q <= '0;
      nib_q <= 1'b0;
      ofr_q <= flash_pkg::FREE_MODE_RST;
      wrap_on_q <= flash_pkg::WRAP_ON_RST; // [RULE12]
      wrap_sel_q <= flash_pkg::WRAP_SEL_RST;
      latch_q <= flash_pkg::LATCH_RST;
      busy_q <= 1'b0;
      ptr_q <= '0;
      mask_q <= '0;
      out_q <= 4'h0;
      oe_q <= 4'h0;
    end else if (CLK_EN) begin
      state_q <= state_d;
      op_q <= op_d;
      cnt_q <= cnt_d;
      sr_q <= sr_d;
      addr_q <= addr_d;
      nib_q <= nib_d;
      ofr_q <= ofr_d;
      wrap_on_q <= wrap_on_d;
      wrap_sel_q <= wrap_sel_d;
      latch_q <= latch_d;
      busy_q <= busy_d;
      ptr_q <= ptr_d;
      mask_q <= mask_d;
      out_q <= out_d;
      oe_q <= oe_d;
    end
  end

  // array content has no reset; only cleared bytes are defined
  always_ff @(posedge CORE_CLK) begin
    if (!RST && CLK_EN && busy_q) begin
      mem[ptr_q] <= flash_pkg::ERASED_BYTE; // [RULE16] [RULE21] [RULE22]
    end
  end

  assign IO_OUT = out_q;
  assign IO_OE = oe_q;
  assign WRITE_IN_PROGRESS_FLAG = busy_q;
  assign WRITE_ENABLE_LATCH = latch_q;
  assign OPCODE_FREE_READ_MODE = ofr_q;
  assign BURST_WRAP_ENABLE = wrap_on_q;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST || !CLK_EN);

  sequence s_cmd_done;
    rise && state_q == ST_CMD && cnt_q == flash_pkg::CMD_LAST;
  endsequence
  sequence s_mode_done;
    rise && state_q == ST_MODE && cnt_q == flash_pkg::MODE_LAST;
  endsequence

  a_idle_no_drive: assert property ( // [RULE2]
    state_q == ST_IDLE |-> IO_OE == 4'h0)
    else $error("lanes driven while idle");
  a_busy_rejects: assert property ( // [RULE5]
    s_cmd_done ##0 (busy_q && cmd_quad) |=> state_q == ST_DROP)
    else $error("quad read taken while busy");
  a_mode_keep: assert property ( // [RULE7]
    s_mode_done ##0 mode_toggle |=> ofr_q && state_q == ST_DUMMY)
    else $error("toggling mode byte did not keep mode");
  a_mode_exit: assert property ( // [RULE9]
    s_mode_done ##0 !mode_toggle |=> !ofr_q)
    else $error("non toggling mode byte kept mode");
  a_free_entry: assert property ( // [RULE8]
    cs_fall && ofr_q && !busy_q |=> state_q == ST_ADDR && op_qio)
    else $error("opcode-free mode expected address first");
  a_dual_no_mode: assert property ( // [RULE11]
    s_cmd_done ##0 cmd == flash_pkg::OP_DUAL_IO |=> state_q == ST_DROP)
    else $error("dual io read accepted");
  a_wrap_window: assert property ( // [RULE15]
    fall && state_q == ST_DATA && nib_q && wrap_use && !cs_rise
    |=> (addr_q & ~win_m) == ($past(addr_q) & ~win_m))
    else $error("wrapped read left its window");
  a_linear_step: assert property ( // [RULE3]
    fall && state_q == ST_DATA && nib_q && !wrap_use
    |=> addr_q == $past(addr_q) + 1'b1)
    else $error("read address did not step by one");
  a_end_clears_latch: assert property ( // [RULE19]
    $fell(busy_q) |-> !latch_q)
    else $error("latch still set after clear");
  // keyed on the opcode: a large block mask equals the chip mask at 64 KB
  a_chip_unprot: assert property ( // [RULE22]
    $rose(busy_q) && is_chip |-> $past(PROTECT_LEVEL) == 4'h0)
    else $error("chip clear with protection set");
  a_wrap_after_rst: assert property ( // [RULE12]
    $past(RST) |-> !wrap_on_q)
    else $error("wrap enabled after reset");
endmodule // quad_flash_core

/* shared/flash_pkg.sv */
// Purpose: constants for the quad read and erase command core
// Assumes: opcodes are one byte, sent msb first on lane 0
// Notes: every opcode, count and the latch, wrap and free mode reset values are named here once
// Function
// [RULE1] host sets quad lane enable before either quad read command
// [RULE2] address sampled on sclk rise, read nibbles change on sclk fall
// [RULE3] read address steps per byte and wraps to zero at array top
// [RULE4] quad output read: opcode, 24 address bits serial, 8 dummies, data
// [RULE5] quad reads are refused while an internal write cycle runs
// [RULE6] quad io read: opcode, 6 address clocks, 2+4 dummies, data
// [RULE7] mode byte with upper nibble inverse of lower keeps opcode-free mode
// [RULE8] in opcode-free mode the first clocks after select are address
// [RULE9] mode byte with any matching nibble bit leaves opcode-free mode
// [RULE10] an all-ones mode byte also ends opcode-free mode
// [RULE11] dual io read never enters opcode-free mode
// [RULE12] wrapped bursts off after reset, kept until reset or disabled
// [RULE13] wrap setup: opcode then one wrap code byte, then select high
// [RULE14] wrap codes 00h..03h pick 8..64 bytes, 1xh switches wrap off
// [RULE15] wrapped quad io reads stay in the aligned window of start
// [RULE16] sector clear sets one 4 KB sector to ones unless protected
// [RULE17] host sets write enable latch before any clear command
// [RULE18] address clears run only if select rises right after 24 bits
// [RULE19] busy flag high during clear, low at end, latch cleared then
// [RULE20] half block clear of protected block still drops the latch
// [RULE21] large block clear sets 64 KB to ones unless protected
// [RULE22] chip clear has no address, runs only with all protect bits 0
package flash_pkg;
  localparam logic [7:0] OP_QUAD_OUT = 8'h6b;
  localparam logic [7:0] OP_QUAD_IO = 8'heb;
  localparam logic [7:0] OP_DUAL_IO = 8'hbb;
  localparam logic [7:0] OP_WRAP = 8'hc0;
  localparam logic [7:0] OP_WR_ENABLE = 8'h06;
  localparam logic [7:0] OP_SECTOR = 8'h20;
  localparam logic [7:0] OP_HALF = 8'h52;
  localparam logic [7:0] OP_LARGE = 8'hd8;
  localparam logic [7:0] OP_CHIP = 8'hc7;
  localparam logic [7:0] OP_CHIP_ALT = 8'h60;
  localparam logic [4:0] CMD_LAST = 5'h07;
  localparam logic [4:0] SER_ADDR_LAST = 5'h17;
  localparam logic [4:0] QIO_ADDR_LAST = 5'h05;
  localparam logic [4:0] WRAP_LAST = 5'h07;
  localparam logic [4:0] MODE_LAST = 5'h01;
  localparam logic [4:0] QIO_DUMMY_LAST = 5'h03;
  localparam logic [4:0] QOUT_DUMMY_LAST = 5'h07;
  localparam int SECTOR_SHIFT = 12;
  localparam int HALF_SHIFT = 15;
  localparam int LARGE_SHIFT = 16;
  localparam int WRAP_OFF_BIT = 4;
  localparam logic [6:0] WRAP_MIN_BYTES = 7'h08;
  localparam logic LATCH_RST = 1'b0;
  localparam logic WRAP_ON_RST = 1'b0;
  localparam logic [1:0] WRAP_SEL_RST = 2'h0;
  localparam logic FREE_MODE_RST = 1'b0;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
endpackage

/* verification/host_link.sv */
// Purpose: host side of the quad link, drives select, link clock, lanes
// Assumes: mode 0 link, 200 ns link clock, lanes read late in high phase
// Notes: released lanes toggle every clock so stale values never pass
module host_link (
  output logic cs_n,
  output logic sclk,
  output logic [3:0] io_in,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    io_in = 4'h5;
  end

  // read nibble is sampled just before the fall that replaces it
  task automatic tick(input logic [3:0] v, output logic [3:0] s);
    io_in = v;
    #100 sclk = 1'b1;
    #95 s = io_out;
    #5 sclk = 1'b0;
  endtask

  // serial bits on lane 0, quad nibbles, dummies, then read nibbles
  task automatic frame(input int ns, input logic [39:0] sb, input int nq,
      input logic [31:0] qn, input int nd, input int nr,
      output logic [31:0] rd, output logic oe);
    logic [3:0] s;
    oe = 1'b0;
    rd = 32'h0;
    cs_n = 1'b0;
    for (int i = ns - 1; i >= 0; i--) begin
      tick({~io_in[3:1], sb[i]}, s);
      oe |= |io_oe;
    end
    for (int i = nq - 1; i >= 0; i--) begin
      tick(qn[4*i +: 4], s);
      oe |= |io_oe;
    end
    for (int i = 0; i < nd + nr; i++) begin
      tick(~io_in, s);
      oe |= |io_oe;
      if (i >= nd) begin
        rd = {rd[27:0], s};
      end
    end
    // select rises right after the last latched bit
    #100 cs_n = 1'b1;
    io_in = ~io_in;
    #200;
  endtask
endmodule // host_link

/* verification/test_serial_flash_quad_read_erase.sv */
// Purpose: self-checking bench for the quad read and clear command core
// Assumes: ADDR_W of 16 keeps clear times short; sector 0 is the only one cleared before the reads
// Notes: only sector 0 reads as ones, the rest of the array stays unknown
module test_serial_flash_quad_read_erase;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int AW = 16;
  logic clk, rst, cs_n, sclk, quad_en, oe, on;
  logic busy, latch, free_mode, wrap_on;
  logic [3:0] io_in, io_out, io_oe, prot;
  logic [31:0] rd, r;
  logic [31:0] seed = 32'h55;
  logic [23:0] a;
  logic [7:0] m;
  logic [7:0] corner [8] = '{8'ha5, 8'hff, 8'h5a, 8'h00,
                             8'hf0, 8'haa, 8'h0f, 8'h55};
  int miscompares = 0;
  int comparisons = 0;
  int cyc = 0;

  quad_flash_core #(.ADDR_W(AW)) quad_flash_core_i (.CORE_CLK(clk),
    .RST(rst), .CLK_EN(1'b1), .CS_N(cs_n), .SCLK(sclk), .IO_IN(io_in),
    .IO_OUT(io_out), .IO_OE(io_oe), .QUAD_LANE_ENABLE_BIT(quad_en),
    .PROTECT_LEVEL(prot), .WRITE_IN_PROGRESS_FLAG(busy),
    .WRITE_ENABLE_LATCH(latch), .OPCODE_FREE_READ_MODE(free_mode),
    .BURST_WRAP_ENABLE(wrap_on));
  host_link host_link_i (.cs_n(cs_n), .sclk(sclk), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic toggles(input logic [7:0] v);
    return (v[7:4] ^ v[3:0]) == 4'hf;
  endfunction

  task automatic chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic cmd(input logic [39:0] b, input int n);
    host_link_i.frame(n, b, 0, 32'h0, 0, 0, rd, oe);
  endtask

  task automatic qio(input logic op, input logic [23:0] ad,
      input logic [7:0] md);
    host_link_i.frame(op ? 8 : 0, 40'(flash_pkg::OP_QUAD_IO), 8, {ad, md},
      4, 8, rd, oe);
  endtask

  // l of 0 means a linear read with rollover at the array top
  task automatic bytes(input logic [23:0] ad, input int l);
    logic [15:0] e;
    chk(oe === 1'b1, "lanes not driven");
    for (int k = 0; k < 4; k++) begin
      e = (l == 0) ? ad[15:0] + 16'(k) : (ad[15:0] & ~16'(l - 1)) |
          ((ad[15:0] + 16'(k)) & 16'(l - 1));
      chk((rd[8*(3-k) +: 8] === 8'hff) === (e < 16'h1000), "read byte");
    end
  endtask

  task automatic idle(input int lim);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk(busy === 1'b0, "busy never dropped");
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ceiling above the roughly 80k cycles, most of them the chip clear
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      miscompares++;
      $display("[ERR] %0t timeout", $time);
      end_sim();
    end
  end

  initial begin
    rst = 1'b1;
    quad_en = 1'b1;
    prot = 4'h0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    chk(busy === 1'b0 && latch === 1'b0 && free_mode === 1'b0,
      "reset flags");
    chk(wrap_on === 1'b0, "wrap on after reset");
    $display("test reset done");
    cmd(40'({flash_pkg::OP_SECTOR, 24'h000abc}), 32);
    chk(busy === 1'b0 && latch === 1'b0, "clear without latch");
    cmd(40'(flash_pkg::OP_WR_ENABLE), 8);
    chk(latch === 1'b1, "latch not set");
    cmd({7'h0, flash_pkg::OP_SECTOR, 24'h000abc, 1'b0}, 33);
    chk(busy === 1'b0 && latch === 1'b1, "extra clock ran");
    @(negedge clk) prot = 4'h1;
    cmd(40'({flash_pkg::OP_SECTOR, 24'h000abc}), 32);
    chk(busy === 1'b0 && latch === 1'b1, "protected sector");
    cmd(40'({flash_pkg::OP_LARGE, 24'h00f000}), 32);
    chk(busy === 1'b0 && latch === 1'b1, "protected block");
    cmd(40'(flash_pkg::OP_CHIP), 8);
    chk(busy === 1'b0 && latch === 1'b1, "protected chip");
    cmd(40'({flash_pkg::OP_HALF, 24'h000000}), 32);
    idle(1000);
    chk(latch === 1'b0, "half block kept latch");
    @(negedge clk) prot = 4'h0;
    $display("test refusals done");
    cmd(40'(flash_pkg::OP_WR_ENABLE), 8);
    cmd(40'({flash_pkg::OP_SECTOR, 24'h000abc}), 32);
    chk(busy === 1'b1, "clear not started");
    qio(1'b1, 24'h0, 8'h00);
    chk(oe === 1'b0 && busy === 1'b1, "read while busy");
    idle(5000);
    chk(latch === 1'b0, "latch kept after clear");
    $display("test sector clear done");
    host_link_i.frame(32, 40'({flash_pkg::OP_QUAD_OUT, 24'h00ffff}), 0,
      32'h0, 8, 8, rd, oe);
    bytes(24'h00ffff, 0);
    @(negedge clk) quad_en = 1'b0;
    qio(1'b1, 24'h0, 8'h00);
    chk(oe === 1'b0, "quad read without enable");
    @(negedge clk) quad_en = 1'b1;
    host_link_i.frame(8, 40'(flash_pkg::OP_DUAL_IO), 8, 32'ha5, 4, 8, rd, oe);
    chk(oe === 1'b0 && free_mode === 1'b0, "dual io read");
    $display("test quad reads done");
    for (int i = 0; i < 5; i++) begin
      m = (i < 4) ? 8'(i) : 8'h10;
      cmd(40'({flash_pkg::OP_WRAP, m}), 16);
      chk(wrap_on === (i < 4), "wrap enable");
      qio(1'b1, 24'h000ffe, 8'h00);
      bytes(24'h000ffe, (i < 4) ? 8 << i : 0);
    end
    cmd(40'({flash_pkg::OP_WRAP, 8'h02}), 16);
    @(negedge clk) rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    chk(wrap_on === 1'b0, "wrap kept over reset");
    $display("test wrap done");
    on = 1'b0;
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      m = (i < 8) ? corner[i] : r[7:0];
      r = rnd();
      a = r[23:0];
      qio(!on, a, m);
      bytes(a, 0);
      on = toggles(m);
      chk(free_mode === on, "opcode free mode");
    end
    $display("test opcode free mode done");
    // leave the mode first, or the clear opcodes would read as address
    qio(!on, 24'h000000, 8'hff);
    bytes(24'h000000, 0);
    chk(free_mode === 1'b0, "all ones mode byte kept mode");
    cmd(40'(flash_pkg::OP_WR_ENABLE), 8);
    cmd(40'(flash_pkg::OP_CHIP), 8);
    chk(busy === 1'b1, "chip clear not started");
    idle(70000);
    chk(latch === 1'b0, "latch kept after chip clear");
    $display("test chip clear done");
    end_sim();
  end
endmodule // test_serial_flash_quad_read_erase
